// file: rtl/sdram_legal_defines.svh
/*
 * Constants of the bank command legality block: clock period, documented
 * timing figures in nanoseconds and the cycle counts derived from them.
 * Assumes a 250 MHz clock; included by bare name from the design files.
 */
// Operation
// - Read with auto_precharge idles after row_precharge_time
// - Write with auto_precharge idles after row_precharge_time
// - Per-bank refresh idles bank after its cycle time
// - All-bank refresh idles device after its cycle time
// - Idle mode read ends all-idle after delay
// - Resetting mode read ends all-idle after delay
// - Active mode read returns to active after delay
// - Mode write ends all-idle after write delay
// - Precharge-all ends all-idle after row_precharge_time
// - Precharging idle bank still waits row_precharge_time
// - Burst terminate ends most recent burst
// - Idle bank n never restricts bank m
// - Busy bank n allows activate/read/write/precharge on m (code refuses read/write on m while an opposite-direction burst is open)
// - Mode read beside busy banks enters mode-read state (code refuses it while any bank reads, writes, auto-precharges or refreshes)
// - Reset mode write from power-on starts resetting
// - Resetting accepts only mode register read
`ifndef SDRAM_LEGAL_DEFINES_SVH
`define SDRAM_LEGAL_DEFINES_SVH

// Clock
`define CLK_PERIOD_PS                 4000

// Timing figures in nanoseconds
`define ROW_PRECHARGE_TIME_NS         18
`define PER_BANK_REFRESH_CYCLE_NS     90
`define ALL_BANK_REFRESH_CYCLE_NS     130
`define MODE_REG_READ_DELAY_NS        8
`define MODE_REG_WRITE_DELAY_NS       20
`define RESET_INIT_TIME_NS            10000

// Least times round up to whole cycles
`define NS_TO_CYC(ns)                 ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Burst length on the data pins, in clock cycles
`define BURST_CYCLES                  4

// Geometry and counter width
`define NUM_BANKS                     8
`define TIMER_W                       16

`endif

// file: rtl/sdram_legal_pkg.sv
/*
 * Types shared by the bank state machines and the device-level checker.
 * Assumes the constants header is on the include path.
 */
`include "sdram_legal_defines.svh"

package sdram_legal_pkg;

    typedef logic [`TIMER_W-1:0] timer_t;

    // Commands as decoded from the command/address bus
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REFPB,
        CMD_REFAB, CMD_MRR, CMD_MRW, CMD_BST
    } cmd_t;

    // Per-bank state
    typedef enum logic [3:0] {
        BK_IDLE, BK_ACTIVE, BK_READING, BK_WRITING, BK_READ_AP,
        BK_WRITE_AP, BK_PRECHARGING, BK_REFRESHING
    } bank_state_t;

    // Device-level state
    typedef enum logic [3:0] {
        DEV_POWER_ON, DEV_RESETTING, DEV_RESET_MRR, DEV_NORMAL,
        DEV_IDLE_MRR, DEV_ACTIVE_MRR, DEV_MRW, DEV_REF_ALL, DEV_PRE_ALL
    } dev_state_t;

    typedef struct packed {
        bank_state_t state;
        timer_t      timer;
    } bank_reg_t;

    typedef struct packed {
        dev_state_t         dev;
        timer_t             devTimer;
        logic               burstOn;
        logic               burstRead;
        logic [2:0]         burstBank;
        logic [7:0]         burstCnt;
        logic               accepted;
        logic               rejected;
    } top_reg_t;

endpackage

// file: rtl/sdram_bank_fsm.sv
/*
 * One bank's state machine: tracks idle, active, burst and timed states.
 * Assumes the parent has already judged each command legal before go.
 */
`timescale 1ns/100ps
`default_nettype none

module sdram_bank_fsm
    import sdram_legal_pkg::*;
#(
    parameter int unsigned RP_CYC    = `NS_TO_CYC(`ROW_PRECHARGE_TIME_NS),
    parameter int unsigned RFCPB_CYC = `NS_TO_CYC(`PER_BANK_REFRESH_CYCLE_NS)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Accepted command for this bank
    input  wire logic        cmdGo,
    input  wire cmd_t        cmdSel,
    input  wire logic        autoPre,
    // Burst in this bank has ended (completion, terminate or takeover)
    input  wire logic        burstEnd,
    // State
    output bank_state_t      bankState
);

    bank_reg_t cur;
    bank_reg_t next_cur;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_cur = cur;
        if (cmdGo) begin
            case (cmdSel)
                CMD_ACT: begin
                    next_cur.state = BK_ACTIVE;
                end
                CMD_READ: begin
                    next_cur.state = autoPre ? BK_READ_AP : BK_READING;
                end
                CMD_WRITE: begin
                    next_cur.state = autoPre ? BK_WRITE_AP : BK_WRITING;
                end
                CMD_PRE: begin
                    // Even an idle bank must sit out the full precharge
                    next_cur.state = BK_PRECHARGING;
                    next_cur.timer = timer_t'(RP_CYC);
                end
                CMD_REFPB: begin
                    next_cur.state = BK_REFRESHING;
                    next_cur.timer = timer_t'(RFCPB_CYC);
                end
                default: ;
            endcase
        end else if (burstEnd) begin
            case (cur.state)
                BK_READING, BK_WRITING: begin
                    next_cur.state = BK_ACTIVE;
                end
                BK_READ_AP, BK_WRITE_AP: begin
                    // Auto precharge follows the burst, then row_precharge_time
                    next_cur.state = BK_PRECHARGING;
                    next_cur.timer = timer_t'(RP_CYC);
                end
                default: ;
            endcase
        end else if (cur.state inside {BK_PRECHARGING, BK_REFRESHING}) begin
            // Timed states count down and fall to idle
            if (cur.timer <= timer_t'(1)) begin
                next_cur.state = BK_IDLE;
                next_cur.timer = '0;
            end else begin
                next_cur.timer = cur.timer - timer_t'(1);
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '{state: BK_IDLE, timer: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign bankState = cur.state;

endmodule

`default_nettype wire

// file: rtl/sdram_bank_command_legality.sv
/*
 * Device-side command legality: judges each registered command against the
 * device state, the bank states and the open burst, and drives the banks.
 * Assumes commands arrive decoded, one per clock, synchronous to clk, with
 * the clock enable high; power-down and self refresh lie outside.
 */
`timescale 1ns/100ps
`default_nettype none

module sdram_bank_command_legality
    import sdram_legal_pkg::*;
#(
    parameter int unsigned NUM_BANKS  = `NUM_BANKS,
    parameter int unsigned RP_CYC     = `NS_TO_CYC(`ROW_PRECHARGE_TIME_NS),
    parameter int unsigned RFCPB_CYC  = `NS_TO_CYC(`PER_BANK_REFRESH_CYCLE_NS),
    parameter int unsigned RFCAB_CYC  = `NS_TO_CYC(`ALL_BANK_REFRESH_CYCLE_NS),
    parameter int unsigned MRR_CYC    = `NS_TO_CYC(`MODE_REG_READ_DELAY_NS),
    parameter int unsigned MRW_CYC    = `NS_TO_CYC(`MODE_REG_WRITE_DELAY_NS),
    parameter int unsigned INIT_CYC   = `NS_TO_CYC(`RESET_INIT_TIME_NS),
    parameter int unsigned BURST_CYC  = `BURST_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Decoded command, one per clock
    input  wire cmd_t                        cmdCode,
    input  wire logic [2:0]                  cmdBank,
    input  wire logic                        cmdAutoPre,
    input  wire logic                        cmdAllBanks,
    input  wire logic                        cmdMrwReset,
    // Verdict on the previous cycle's command
    output logic                             cmdAccepted,
    output logic                             cmdRejected,
    // State
    output dev_state_t                       devState,
    output bank_state_t [NUM_BANKS-1:0]      bankState,
    output logic                             burstActive,
    output logic [2:0]                       burstBank
);

    top_reg_t                   cur;
    top_reg_t                   next_cur;
    logic [NUM_BANKS-1:0]       goVec;
    logic [NUM_BANKS-1:0]       endVec;
    logic                       legal;
    logic                       allIdle;
    logic                       anyBusyForMrr;
    logic                       anyApOrRefresh;
    bank_state_t                selState;

    // ************************************************************
    // Bank state machines
    // ************************************************************
    for (genvar gb = 0; gb < NUM_BANKS; gb++) begin : gBank
        sdram_bank_fsm #(
            .RP_CYC    (RP_CYC),
            .RFCPB_CYC (RFCPB_CYC)
        ) uBank (
            .clk       (clk),
            .rst_b     (rst_b),
            .cmdGo     (goVec[gb]),
            .cmdSel    (cmdCode),
            .autoPre   (cmdAutoPre),
            .burstEnd  (endVec[gb]),
            .bankState (bankState[gb])
        );
    end

    // ************************************************************
    // Summaries over all banks
    // ************************************************************
    // Bank n only restricts bank m through these summaries and the open burst; an idle bank
    // adds nothing to any of them, so it never blocks another bank
    always_comb begin
        allIdle        = 1'b1;
        anyBusyForMrr  = 1'b0;
        anyApOrRefresh = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bankState[i] != BK_IDLE) begin
                allIdle = 1'b0;
            end
            if (bankState[i] inside {BK_READING, BK_WRITING, BK_READ_AP, BK_WRITE_AP, BK_REFRESHING}) begin
                anyBusyForMrr = 1'b1;
            end
            if (bankState[i] inside {BK_READ_AP, BK_WRITE_AP, BK_REFRESHING}) begin
                anyApOrRefresh = 1'b1;
            end
        end
    end

    assign selState = bankState[cmdBank];

    // ************************************************************
    // Legality and next state
    // ************************************************************
    always_comb begin
        next_cur          = cur;
        next_cur.accepted = 1'b0;
        next_cur.rejected = 1'b0;
        goVec             = '0;
        endVec            = '0;
        legal             = 1'b0;

        // Open burst runs down on its own; completion frees the bank
        if (cur.burstOn) begin
            if (cur.burstCnt <= 8'h01) begin
                next_cur.burstOn = 1'b0;
                endVec[cur.burstBank] = 1'b1;
            end else begin
                next_cur.burstCnt = cur.burstCnt - 8'h01;
            end
        end

        case (cur.dev)
            DEV_POWER_ON: begin
                // Only the reset mode write leaves power-on
                if (cmdCode == CMD_MRW && cmdMrwReset) begin
                    legal             = 1'b1;
                    next_cur.dev      = DEV_RESETTING;
                    next_cur.devTimer = timer_t'(INIT_CYC);
                end
            end
            DEV_RESETTING: begin
                // Initialization time runs; only mode reads are taken
                if (cmdCode == CMD_MRR) begin
                    legal             = 1'b1;
                    next_cur.dev      = DEV_RESET_MRR;
                    next_cur.devTimer = timer_t'(MRR_CYC);
                end else if (cur.devTimer <= timer_t'(1)) begin
                    next_cur.dev      = DEV_NORMAL;
                end else begin
                    next_cur.devTimer = cur.devTimer - timer_t'(1);
                end
            end
            DEV_PRE_ALL: begin
                // Banks time their own precharge; done once all are idle
                if (allIdle) begin
                    next_cur.dev = DEV_NORMAL;
                end
            end
            DEV_RESET_MRR, DEV_IDLE_MRR, DEV_ACTIVE_MRR, DEV_MRW, DEV_REF_ALL: begin
                // Protected: any executable command is refused
                // All end in normal operation; banks kept their own state,
                // so an active mode read leaves its banks active
                if (cur.devTimer <= timer_t'(1)) begin
                    next_cur.dev      = DEV_NORMAL;
                    next_cur.devTimer = '0;
                end else begin
                    next_cur.devTimer = cur.devTimer - timer_t'(1);
                end
            end
            DEV_NORMAL: begin
                case (cmdCode)
                    CMD_ACT: begin
                        // Other banks' activity never blocks an activate
                        legal = (selState == BK_IDLE);
                        if (legal) begin
                            goVec[cmdBank] = 1'b1;
                        end
                    end
                    CMD_READ, CMD_WRITE: begin
                        // Column access to an open row; opposite burst must be over
                        legal = (selState inside {BK_ACTIVE, BK_READING, BK_WRITING}) &&
                                !(cur.burstOn && (cur.burstRead != (cmdCode == CMD_READ)));
                        if (legal) begin
                            goVec[cmdBank] = 1'b1;
                            // A new burst in another bank cuts the old one short in the old burst's bank
                            if (cur.burstOn && cur.burstBank != cmdBank) begin
                                endVec[cur.burstBank] = 1'b1;
                            end
                            next_cur.burstOn   = 1'b1;
                            next_cur.burstRead = (cmdCode == CMD_READ);
                            next_cur.burstBank = cmdBank;
                            next_cur.burstCnt  = 8'(BURST_CYC);
                        end
                    end
                    CMD_PRE: begin
                        if (cmdAllBanks) begin
                            // Every bank must be in a state that may be precharged
                            legal = !anyApOrRefresh;
                            if (legal) begin
                                goVec            = '1;
                                next_cur.burstOn = 1'b0;
                                next_cur.dev     = DEV_PRE_ALL;
                            end
                        end else begin
                            // No command to a bank under an auto precharge burst
                            legal = !(selState inside {BK_READ_AP, BK_WRITE_AP, BK_REFRESHING});
                            if (legal) begin
                                goVec[cmdBank] = 1'b1;
                                if (cur.burstOn && cur.burstBank == cmdBank) begin
                                    next_cur.burstOn = 1'b0;
                                end
                            end
                        end
                    end
                    CMD_REFPB: begin
                        // Bank must be idle with no burst open
                        legal = (selState == BK_IDLE) && !cur.burstOn;
                        if (legal) begin
                            goVec[cmdBank] = 1'b1;
                        end
                    end
                    CMD_REFAB: begin
                        legal = allIdle && !cur.burstOn;
                        if (legal) begin
                            next_cur.dev      = DEV_REF_ALL;
                            next_cur.devTimer = timer_t'(RFCAB_CYC);
                        end
                    end
                    CMD_MRW: begin
                        legal = allIdle && !cur.burstOn;
                        if (legal && cmdMrwReset) begin
                            next_cur.dev      = DEV_RESETTING;
                            next_cur.devTimer = timer_t'(INIT_CYC);
                        end else if (legal) begin
                            next_cur.dev      = DEV_MRW;
                            next_cur.devTimer = timer_t'(MRW_CYC);
                        end
                    end
                    CMD_MRR: begin
                        // Allowed beside activating, active or precharging banks
                        legal = !anyBusyForMrr && !cur.burstOn;
                        if (legal) begin
                            next_cur.dev      = allIdle ? DEV_IDLE_MRR : DEV_ACTIVE_MRR;
                            next_cur.devTimer = timer_t'(MRR_CYC);
                        end
                    end
                    CMD_BST: begin
                        // Bank field ignored: the most recent burst ends
                        legal = cur.burstOn;
                        if (legal) begin
                            endVec[cur.burstBank] = 1'b1;
                            next_cur.burstOn      = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            default: begin
                next_cur.dev = DEV_POWER_ON;
            end
        endcase

        // Refused commands are ignored; only the flag shows it
        if (cmdCode != CMD_NOP) begin
            next_cur.accepted = legal;
            next_cur.rejected = !legal;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0; // All-zero encodes power-on, no burst, no verdict
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign cmdAccepted = cur.accepted;
    assign cmdRejected = cur.rejected;
    assign devState    = cur.dev;
    assign burstActive = cur.burstOn;
    assign burstBank   = cur.burstBank;

endmodule

`default_nettype wire

// file: verif/host_cmd_model.sv
/*
 * Host controller model: puts one decoded command on the bus per request.
 * Assumes the bench asks for each command in turn, illegal ones included.
 */
`timescale 1ns/100ps
`default_nettype none

module host_cmd_model
    import sdram_legal_pkg::*;
(
    // Clock
    input  wire logic  clk,
    // Command bus toward the device
    output var cmd_t   cmdCode,
    output logic [2:0] cmdBank,
    output logic       cmdAutoPre,
    output logic       cmdAllBanks,
    output logic       cmdMrwReset
);
    // **********
    // Driver
    // **********
    // Bus idles on NOP, so between requests protected states and auto precharge bursts see nothing else
    initial begin
        cmdCode = CMD_NOP;
        cmdBank = 3'h0;
        {cmdAutoPre, cmdAllBanks, cmdMrwReset} = 3'h0;
    end

    // One cycle of command, then NOP with stale fields inverted
    task automatic send(input cmd_t c, input logic [2:0] b, input logic [2:0] f);
        @(posedge clk);
        cmdCode <= c;
        cmdBank <= b;
        {cmdAutoPre, cmdAllBanks, cmdMrwReset} <= f;
        @(posedge clk);
        cmdCode <= CMD_NOP;
        cmdBank <= ~b;
        {cmdAutoPre, cmdAllBanks, cmdMrwReset} <= ~f;
    endtask
endmodule
`default_nettype wire

// file: verif/sdram_legality_checker.sv
/*
 * Assertions on verdicts and timed states of the command legality block.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module sdram_legality_checker
    import sdram_legal_pkg::*;
#(
    parameter int NUM_BANKS = 8,
    parameter int RP_CYC    = 5,
    parameter int RFCPB_CYC = 23,
    parameter int RFCAB_CYC = 33,
    parameter int MRR_CYC   = 2,
    parameter int MRW_CYC   = 5
) (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        rst_b,
    // Command
    input wire cmd_t                        cmdCode,
    input wire logic [2:0]                  cmdBank,
    input wire logic                        cmdMrwReset,
    // Verdict and state
    input wire logic                        cmdAccepted,
    input wire logic                        cmdRejected,
    input wire dev_state_t                  devState,
    input wire bank_state_t [NUM_BANKS-1:0] bankState,
    input wire logic                        burstActive
);
    // **********
    // Properties
    // **********
    // One cycle of slack on each timed state, two on precharge-all
    localparam int RP_LIM = RP_CYC + 1;
    localparam int PA_LIM = RP_CYC + 2;
    localparam int PB_LIM = RFCPB_CYC + 1;
    localparam int AB_LIM = RFCAB_CYC + 1;
    localparam int MR_LIM = MRR_CYC + 1;
    localparam int MW_LIM = MRW_CYC + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    verdict_one_a: assert property (cmdCode != CMD_NOP
        |=> cmdAccepted != cmdRejected) else $error("no single verdict");
    reset_start_a: assert property (devState == DEV_POWER_ON && cmdCode == CMD_MRW && cmdMrwReset
        |=> cmdAccepted && devState == DEV_RESETTING) else $error("reset write ignored");
    reset_mrr_a: assert property (devState == DEV_RESETTING && cmdCode == CMD_MRR
        |=> cmdAccepted && devState == DEV_RESET_MRR) else $error("mode read refused");
    protect_refuse_a: assert property (cmdCode != CMD_NOP && devState inside {DEV_RESET_MRR,
        DEV_IDLE_MRR, DEV_ACTIVE_MRR, DEV_MRW, DEV_REF_ALL, DEV_PRE_ALL} |=> cmdRejected) else $error("took cmd");
    mrr_end_a: assert property (devState inside {DEV_IDLE_MRR, DEV_RESET_MRR, DEV_ACTIVE_MRR}
        |-> ##[1:MR_LIM] devState == DEV_NORMAL) else $error("mode read never ended");
    mrw_end_a: assert property (devState == DEV_MRW
        |-> ##[1:MW_LIM] devState == DEV_NORMAL) else $error("mode write never ended");
    refab_end_a: assert property (devState == DEV_REF_ALL
        |-> ##[1:AB_LIM] devState == DEV_NORMAL) else $error("refresh never ended");
    preall_end_a: assert property (devState == DEV_PRE_ALL
        |-> ##[1:PA_LIM] devState == DEV_NORMAL) else $error("precharge all never ended");
    bst_end_a: assert property (cmdCode == CMD_BST && burstActive
        |=> cmdAccepted && !burstActive) else $error("burst not ended");
    act_idle_a: assert property (devState == DEV_NORMAL && cmdCode == CMD_ACT && bankState[cmdBank] == BK_IDLE
        |=> cmdAccepted && bankState[$past(cmdBank)] == BK_ACTIVE) else $error("activate refused");
    // Every bank leaves its timed states within the bound
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        prech_idle_a: assert property (bankState[i] == BK_PRECHARGING
            |-> ##[1:RP_LIM] bankState[i] == BK_IDLE) else $error("bank stuck precharging");
        refresh_end_a: assert property (bankState[i] == BK_REFRESHING
            |-> ##[1:PB_LIM] bankState[i] == BK_IDLE) else $error("bank stuck refreshing");
    end
endmodule

bind sdram_bank_command_legality sdram_legality_checker #(.NUM_BANKS(NUM_BANKS), .RP_CYC(RP_CYC),
    .RFCPB_CYC(RFCPB_CYC), .RFCAB_CYC(RFCAB_CYC), .MRR_CYC(MRR_CYC), .MRW_CYC(MRW_CYC)) chk (.*);
`default_nettype wire

// file: verif/tb_sdram_bank_command_legality.sv
/*
 * Self-checking bench for the command legality block, with a bank model.
 * Assumes the host model drives the command bus and the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch at %0t: got %0d want %0d", $time, a, e); end end

module tb_sdram_bank_command_legality
    import sdram_legal_pkg::*;
;
    // **********
    // Set-up
    // **********
    // Short refresh and init counts keep the run brief
    localparam int RP = 5;
    localparam int RFC = 4;
    localparam int MRR = 2;
    localparam int MRW = 5;
    localparam logic [2:0] AP = 3'h4;
    localparam logic [2:0] ALL = 3'h2;
    localparam logic [2:0] RST = 3'h1;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    cmd_t              cmdCode;
    logic [2:0]        cmdBank, burstBank, b;
    logic              cmdAutoPre, cmdAllBanks, cmdMrwReset, cmdAccepted, cmdRejected, burstActive;
    dev_state_t        devState;
    bank_state_t [7:0] bankState;
    bank_state_t       bk [8];
    int                n_errors = 0;
    int                samples_checked = 0;

    always #2 clk = ~clk;

    host_cmd_model host (.*);
    sdram_bank_command_legality #(.RP_CYC(RP), .RFCPB_CYC(RFC), .RFCAB_CYC(RFC), .MRR_CYC(MRR),
        .MRW_CYC(MRW), .INIT_CYC(20)) dut (.*);

    // One command, then verdict, device and bank against the model
    task automatic op(cmd_t c, logic [2:0] k, logic [2:0] f, logic acc, dev_state_t d);
        host.send(c, k, f);
        #1;
        `CHK(cmdAccepted, acc)
        `CHK(cmdRejected, !acc)
        `CHK(devState, d)
        `CHK(bankState[k], bk[k])
    endtask

    // Bounded polls for the end of a timed state
    task automatic waitBank(int k, bank_state_t s, int lim);
        repeat (lim) if (bankState[k] !== s) @(posedge clk) #1;
        `CHK(bankState[k], s)
        bk[k] = s;
    endtask
    task automatic waitDev(dev_state_t s, int lim);
        repeat (lim) if (devState !== s) @(posedge clk) #1;
        `CHK(devState, s)
    endtask

    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // **********
    // Scenarios
    // **********
    initial begin
        void'($urandom(32'h8da05d76));
        foreach (bk[i]) bk[i] = BK_IDLE;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK(devState, DEV_POWER_ON)
        op(CMD_ACT, 0, 0, 0, DEV_POWER_ON);
        op(CMD_MRW, 0, RST, 1, DEV_RESETTING);
        op(CMD_ACT, 0, 0, 0, DEV_RESETTING);
        op(CMD_MRR, 0, 0, 1, DEV_RESET_MRR);
        waitDev(DEV_NORMAL, MRR + 2);
        bk[2] = BK_ACTIVE;
        op(CMD_ACT, 2, 0, 1, DEV_NORMAL);
        bk[3] = BK_ACTIVE;
        op(CMD_ACT, 3, 0, 1, DEV_NORMAL);
        bk[2] = BK_READ_AP;
        op(CMD_READ, 2, AP, 1, DEV_NORMAL);
        op(CMD_WRITE, 3, 0, 0, DEV_NORMAL);
        waitBank(2, BK_PRECHARGING, 6);
        waitBank(2, BK_IDLE, RP + 2);
        bk[3] = BK_READING;
        op(CMD_READ, 3, 0, 1, DEV_NORMAL);
        bk[3] = BK_ACTIVE;
        op(CMD_BST, 3, 0, 1, DEV_NORMAL);
        `CHK(burstActive, 1'b0)
        `CHK(burstBank, 3'h3)
        op(CMD_MRR, 0, 0, 1, DEV_ACTIVE_MRR);
        waitDev(DEV_NORMAL, MRR + 2);
        `CHK(bankState[3], BK_ACTIVE)
        bk[3] = BK_WRITE_AP;
        op(CMD_WRITE, 3, AP, 1, DEV_NORMAL);
        waitBank(3, BK_PRECHARGING, 6);
        waitBank(3, BK_IDLE, RP + 2);
        bk[5] = BK_PRECHARGING;
        op(CMD_PRE, 5, 0, 1, DEV_NORMAL);
        op(CMD_REFPB, 5, 0, 0, DEV_NORMAL);
        waitBank(5, BK_IDLE, RP + 2);
        bk[5] = BK_REFRESHING;
        op(CMD_REFPB, 5, 0, 1, DEV_NORMAL);
        waitBank(5, BK_IDLE, RFC + 2);
        foreach (bk[i]) bk[i] = BK_PRECHARGING;
        op(CMD_PRE, 0, ALL, 1, DEV_PRE_ALL);
        op(CMD_ACT, 1, 0, 0, DEV_PRE_ALL);
        waitDev(DEV_NORMAL, RP + 3);
        foreach (bk[i]) `CHK(bankState[i], BK_IDLE)
        foreach (bk[i]) bk[i] = BK_IDLE;
        op(CMD_REFAB, 0, 0, 1, DEV_REF_ALL);
        waitDev(DEV_NORMAL, RFC + 2);
        op(CMD_MRW, 0, 0, 1, DEV_MRW);
        waitDev(DEV_NORMAL, MRW + 2);
        op(CMD_MRR, 0, 0, 1, DEV_IDLE_MRR);
        waitDev(DEV_NORMAL, MRR + 2);
        bk[1] = BK_ACTIVE;
        op(CMD_ACT, 1, 0, 1, DEV_NORMAL);
        op(CMD_REFAB, 0, 0, 0, DEV_NORMAL);
        op(CMD_MRW, 0, 0, 0, DEV_NORMAL);
        // Random banks: open idle ones, close open ones
        for (int i = 0; i < 16; i++) begin
            b = 3'($urandom % 8);
            if (bk[b] == BK_IDLE) begin
                bk[b] = BK_ACTIVE;
                op(CMD_ACT, b, 0, 1, DEV_NORMAL);
            end else begin
                op(CMD_ACT, b, 0, 0, DEV_NORMAL);
                bk[b] = BK_PRECHARGING;
                op(CMD_PRE, b, 0, 1, DEV_NORMAL);
                waitBank(b, BK_IDLE, RP + 2);
            end
        end
        foreach (bk[i]) `CHK(bankState[i], bk[i])
        final_report();
    end

    // Watchdog, far past the scenarios' length
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
